// file: include/pcc_evt_if.sv
// Event and interrupt wiring between the register bank and its helpers
`timescale 1ns/1ps
`default_nettype none
interface pcc_evt_if;
	logic rise_en;
	logic fall_en;
	logic ev_rise;
	logic ev_fall;
	logic ev_det;
	logic sts_wr;
	logic msk_wr;
	logic [pcc_pkg::IRQ_W-1:0] wdata;
	logic [pcc_pkg::IRQ_W-1:0] status;
	logic [pcc_pkg::IRQ_W-1:0] mask;
	modport rpt (input rise_en, input fall_en, output ev_rise, output ev_fall);
	modport irq (input ev_rise, input ev_fall, input ev_det, input sts_wr, input msk_wr, input wdata,
		output status, output mask);
endinterface
`default_nettype wire

// file: include/pcc_pkg.sv
// Shared constants for the power and charger control register bank
// Notes on behaviour
// - Without manual control, charger_found is read-only and shows the hardware detection result.
// - Without manual control, the indicator pin follows detection through the same polarity drive.
// - With manual control, charger_found is writable; 0 releases the pin, 1 drives polarity level.
// - Without manual control, dp_sense_source_en is read-only; hardware drives source, sink and reference.
// - With manual control, dp_sense_source_en switches sensing source, DM sink and reference together.
// - Bit 5 reports whether DM is above the detection reference.
// - Bit 4 enables the DP weak pull-up only in synchronous mode with VBUS session valid.
// - Falling-edge report enable plus BVALID falling sends an RX CMD with alt_int.
// - Rising-edge report enable plus BVALID rising sends an RX CMD with alt_int.
// - Manual control rising edge copies live source status and detection result, exits detection.
// - Bit 1 mirrors the detection result and reads 0 whenever manual control is set.
package pcc_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int IRQ_W = 3;
	localparam logic [ADDR_W-1:0] OFS_POWER = 8'h3D;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h40;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h41;
	localparam int BIT_FOUND = 7;
	localparam int BIT_SRC_EN = 6;
	localparam int BIT_DM_ABOVE = 5;
	localparam int BIT_WKPU = 4;
	localparam int BIT_FALL_EN = 3;
	localparam int BIT_RISE_EN = 2;
	localparam int BIT_DETECTION_COMPLETE = 1;
	localparam int BIT_MANUAL = 0;
	localparam int IRQ_RISE = 0;
	localparam int IRQ_FALL = 1;
	localparam int IRQ_DET = 2;
	localparam logic [DATA_W-1:0] POWER_RESET = 8'h00;
	localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;
	localparam logic [DATA_W-1:0] READ_NONE = 8'h00;
endpackage

// file: rtl/pcc_bvalid_report.sv
// BVALID edge detection and alt_int RX CMD request
`timescale 1ns/1ps
`default_nettype none
module pcc_bvalid_report (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Line and link
	input wire logic bvalid,
	input wire logic alt_int_ack,
	output logic alt_int_req,
	// Events
	pcc_evt_if.rpt evt
);
	typedef struct packed {
		logic primed;
		logic prev;
		logic req;
	} pcc_rpt_st_t;
	pcc_rpt_st_t st_q;
	pcc_rpt_st_t st_d;
	logic rise;
	logic fall;

	// Primed keeps a high BVALID at reset release from looking like an edge
	always_comb begin
		st_d = st_q;
		rise = st_q.primed && bvalid && !st_q.prev;
		fall = st_q.primed && !bvalid && st_q.prev;
		st_d.primed = 1'b1;
		st_d.prev = bvalid;
		// A new edge wins over an ack in the same cycle
		st_d.req = (st_q.req && !alt_int_ack) || (rise && evt.rise_en) || (fall && evt.fall_en);
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign alt_int_req = st_q.req;
	assign evt.ev_rise = rise;
	assign evt.ev_fall = fall;

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_rise_report: assert property (rise && evt.rise_en |=> alt_int_req) else $error("rise not reported");
	a_fall_report: assert property (fall && evt.fall_en |=> alt_int_req) else $error("fall not reported");
	a_req_hold: assert property (alt_int_req && !alt_int_ack |=> alt_int_req) else $error("request dropped");
	c_fall_report: cover property (fall && evt.fall_en ##1 alt_int_req);
endmodule // pcc_bvalid_report
`default_nettype wire

// file: rtl/pcc_irq.sv
// Sticky interrupt status, mask and level output
`timescale 1ns/1ps
`default_nettype none
module pcc_irq (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Interrupt
	output logic irq,
	// Events and register access
	pcc_evt_if.irq evt
);
	typedef struct packed {
		logic [pcc_pkg::IRQ_W-1:0] status;
		logic [pcc_pkg::IRQ_W-1:0] mask;
		logic irq;
	} pcc_irq_st_t;
	pcc_irq_st_t st_q;
	pcc_irq_st_t st_d;
	logic [pcc_pkg::IRQ_W-1:0] ev;

	always_comb begin
		st_d = st_q;
		ev = '0;
		ev[pcc_pkg::IRQ_RISE] = evt.ev_rise;
		ev[pcc_pkg::IRQ_FALL] = evt.ev_fall;
		ev[pcc_pkg::IRQ_DET] = evt.ev_det;
		// Set is applied after the clear so an event in the clearing cycle survives
		if (evt.sts_wr) begin
			st_d.status = st_q.status & ~evt.wdata;
		end
		st_d.status = st_d.status | ev;
		if (evt.msk_wr) begin
			st_d.mask = evt.wdata;
		end
		st_d.irq = |(st_d.status & st_d.mask);
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_q <= {pcc_pkg::IRQ_RESET, pcc_pkg::IRQ_RESET, 1'b0};
		end else begin
			st_q <= st_d;
		end
	end

	assign irq = st_q.irq;
	assign evt.status = st_q.status;
	assign evt.mask = st_q.mask;

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_set_wins: assert property (|ev |=> (evt.status & $past(ev)) == $past(ev)) else $error("event lost");
	a_irq_level: assert property (irq == |(evt.status & evt.mask)) else $error("irq mismatch");
	c_irq_raise: cover property (!irq ##1 irq);
endmodule // pcc_irq
`default_nettype wire

// file: rtl/pcc_power_ctrl.sv
// Power and charger control register bank with detection override
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pcc_power_ctrl (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Register port
	input wire logic [pcc_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [pcc_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	output logic [pcc_pkg::DATA_W-1:0] reg_rdata,
	// Charger detection front end
	input wire logic charger_det_result,
	input wire logic hw_src_live,
	input wire logic dm_above_ref,
	output logic dp_sense_source_on,
	output logic dm_sink_ref_on,
	output logic det_fsm_exit,
	// Line conditions
	input wire logic sync_mode,
	input wire logic vbus_session_valid,
	input wire logic bvalid,
	output logic dp_weak_pullup_on,
	// Charger indicator pin
	input wire logic charger_indicator_polarity,
	output logic charger_indicator_pin_o,
	output logic charger_indicator_pin_oe,
	// Link RX CMD request
	input wire logic rxcmd_alt_int_ack,
	output logic rxcmd_alt_int_req,
	// Interrupt
	output logic irq
);

	////////////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		logic found;
		logic src_en;
		logic dm_above;
		logic wkpu;
		logic fall_en;
		logic rise_en;
		logic manual;
		logic detection_complete;
		logic [pcc_pkg::DATA_W-1:0] rdata;
		logic pin_o;
		logic pin_oe;
		logic src_on;
		logic pullup_on;
	} pcc_main_st_t;

	pcc_main_st_t st_q;
	pcc_main_st_t st_d;
	logic pwr_wr;
	logic man_rise;

	pcc_evt_if evt();

	function automatic logic hit(input logic [pcc_pkg::ADDR_W-1:0] a, input logic [pcc_pkg::ADDR_W-1:0] ofs);
		hit = (a == ofs);
	endfunction

	function automatic logic [pcc_pkg::DATA_W-1:0] widen(input logic [pcc_pkg::IRQ_W-1:0] v);
		widen = {{(pcc_pkg::DATA_W-pcc_pkg::IRQ_W){1'b0}}, v};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		st_d = st_q;
		pwr_wr = reg_we && hit(reg_addr, pcc_pkg::OFS_POWER);
		man_rise = pwr_wr && !st_q.manual && reg_wdata[pcc_pkg::BIT_MANUAL];

		// Enables that software owns in either mode
		if (pwr_wr) begin
			st_d.wkpu = reg_wdata[pcc_pkg::BIT_WKPU];
			st_d.fall_en = reg_wdata[pcc_pkg::BIT_FALL_EN];
			st_d.rise_en = reg_wdata[pcc_pkg::BIT_RISE_EN];
			st_d.manual = reg_wdata[pcc_pkg::BIT_MANUAL];
		end

		// Detection context: software only after manual control is already set
		if (st_q.manual) begin
			if (pwr_wr) begin
				st_d.found = reg_wdata[pcc_pkg::BIT_FOUND];
				st_d.src_en = reg_wdata[pcc_pkg::BIT_SRC_EN];
			end
		end else begin
			// Also covers the takeover write, so the pin does not glitch at handover
			st_d.found = charger_det_result;
			st_d.src_en = hw_src_live;
		end

		// Comparator sampled once; a read shows the previous cycle's level
		st_d.dm_above = dm_above_ref;

		// Completion mirrors detection but is held low under manual control
		st_d.detection_complete = !st_d.manual && charger_det_result;

		// Open-drain style drive: released pin is pulled to the opposite level
		st_d.pin_o = charger_indicator_polarity;
		st_d.pin_oe = st_d.found;

		// One enable feeds source, sink and reference together
		st_d.src_on = st_d.src_en;

		// Pull-up gated by mode and session, one cycle behind its inputs
		st_d.pullup_on = st_q.wkpu && sync_mode && vbus_session_valid;

		// Read data stand for exactly one cycle after the strobe
		st_d.rdata = pcc_pkg::READ_NONE;
		if (reg_re) begin
			if (hit(reg_addr, pcc_pkg::OFS_POWER)) begin
				st_d.rdata[pcc_pkg::BIT_FOUND] = st_q.found;
				st_d.rdata[pcc_pkg::BIT_SRC_EN] = st_q.src_en;
				st_d.rdata[pcc_pkg::BIT_DM_ABOVE] = st_q.dm_above;
				st_d.rdata[pcc_pkg::BIT_WKPU] = st_q.wkpu;
				st_d.rdata[pcc_pkg::BIT_FALL_EN] = st_q.fall_en;
				st_d.rdata[pcc_pkg::BIT_RISE_EN] = st_q.rise_en;
				st_d.rdata[pcc_pkg::BIT_DETECTION_COMPLETE] = st_q.detection_complete;
				st_d.rdata[pcc_pkg::BIT_MANUAL] = st_q.manual;
			end else if (hit(reg_addr, pcc_pkg::OFS_IRQ_STATUS)) begin
				st_d.rdata = widen(evt.status);
			end else if (hit(reg_addr, pcc_pkg::OFS_IRQ_MASK)) begin
				st_d.rdata = widen(evt.mask);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Helpers

	assign evt.rise_en = st_q.rise_en;
	assign evt.fall_en = st_q.fall_en;
	assign evt.ev_det = st_d.detection_complete && !st_q.detection_complete;
	assign evt.sts_wr = reg_we && hit(reg_addr, pcc_pkg::OFS_IRQ_STATUS);
	assign evt.msk_wr = reg_we && hit(reg_addr, pcc_pkg::OFS_IRQ_MASK);
	assign evt.wdata = reg_wdata[pcc_pkg::IRQ_W-1:0];

	pcc_bvalid_report u_report (
		.clk(clk),
		.sys_rst(sys_rst),
		.bvalid(bvalid),
		.alt_int_ack(rxcmd_alt_int_ack),
		.alt_int_req(rxcmd_alt_int_req),
		.evt(evt.rpt)
	);

	pcc_irq u_irq (
		.clk(clk),
		.sys_rst(sys_rst),
		.irq(irq),
		.evt(evt.irq)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign reg_rdata = st_q.rdata;
	assign dp_sense_source_on = st_q.src_on;
	assign dm_sink_ref_on = st_q.src_on;
	assign det_fsm_exit = st_q.manual;
	assign dp_weak_pullup_on = st_q.pullup_on;
	assign charger_indicator_pin_o = st_q.pin_o;
	assign charger_indicator_pin_oe = st_q.pin_oe;

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_found_auto: assert property (
		!st_q.manual |=> st_q.found == $past(charger_det_result)
	) else $error("found does not follow detection");

	a_pin_drive: assert property (
		charger_indicator_pin_oe == st_q.found &&
		(!charger_indicator_pin_oe || charger_indicator_pin_o == $past(charger_indicator_polarity))
	) else $error("indicator pin drive wrong");

	a_found_manual: assert property (
		st_q.manual && pwr_wr |=> st_q.found == $past(reg_wdata[pcc_pkg::BIT_FOUND]) &&
			charger_indicator_pin_oe == $past(reg_wdata[pcc_pkg::BIT_FOUND])
	) else $error("manual found write lost");

	a_src_auto: assert property (
		!st_q.manual |=> st_q.src_en == $past(hw_src_live) && dm_sink_ref_on == $past(hw_src_live)
	) else $error("source does not follow hardware");

	a_src_manual: assert property (
		st_q.manual && pwr_wr |=> dp_sense_source_on == $past(reg_wdata[pcc_pkg::BIT_SRC_EN]) &&
			dm_sink_ref_on == dp_sense_source_on
	) else $error("manual source write lost");

	a_dm_report: assert property (
		reg_re && hit(reg_addr, pcc_pkg::OFS_POWER) && !$past(sys_rst) |=>
			reg_rdata[pcc_pkg::BIT_DM_ABOVE] == $past(dm_above_ref, 2)
	) else $error("comparator bit wrong");

	a_pullup_gate: assert property (
		dp_weak_pullup_on |-> $past(st_q.wkpu && sync_mode && vbus_session_valid)
	) else $error("pull-up on without its conditions");

	a_takeover_copy: assert property (
		$rose(st_q.manual) |-> st_q.found == $past(charger_det_result) &&
			st_q.src_en == $past(hw_src_live) && det_fsm_exit
	) else $error("takeover did not copy context");

	a_det_forced: assert property (
		reg_re && hit(reg_addr, pcc_pkg::OFS_POWER) && st_q.manual |=> !reg_rdata[pcc_pkg::BIT_DETECTION_COMPLETE]
	) else $error("completion not forced low");

	a_auto_ignore: assert property (
		pwr_wr && !st_q.manual && !reg_wdata[pcc_pkg::BIT_MANUAL] |=>
			st_q.found == $past(charger_det_result)
	) else $error("auto mode write changed found");

	a_read_once: assert property (
		!reg_re |=> reg_rdata == pcc_pkg::READ_NONE
	) else $error("read data outside read slot");

	////////////////////////////////////////////////////////////////////////////////
	// Checks on reset, handover, enables and the interrupt map

	// A read in the first cycle after release sees cleared state, not stale data
	a_reset_clear: assert property (
		$past(sys_rst) |->
			{st_q.found, st_q.src_en, st_q.wkpu, st_q.fall_en, st_q.rise_en, st_q.manual} == 6'h00 &&
			reg_rdata == pcc_pkg::POWER_RESET && !charger_indicator_pin_oe && !dp_weak_pullup_on &&
			!rxcmd_alt_int_req && !irq
	) else $error("register not clear after reset");

	a_manual_hold: assert property (
		st_q.manual && !pwr_wr |=>
			$stable(st_q.found) && $stable(st_q.src_en)
	) else $error("manual context moved without a write");

	a_exit_level: assert property (
		pwr_wr |=>
			det_fsm_exit == $past(reg_wdata[pcc_pkg::BIT_MANUAL])
	) else $error("detection exit does not follow manual bit");

	// One cycle after leaving manual control the bits track hardware again
	a_resume_auto: assert property (
		st_q.manual && pwr_wr && !reg_wdata[pcc_pkg::BIT_MANUAL] |=>
			##1 st_q.found == $past(charger_det_result) && st_q.src_en == $past(hw_src_live)
	) else $error("hardware tracking did not resume");

	a_cfg_write: assert property (
		pwr_wr |=> st_q.wkpu == $past(reg_wdata[pcc_pkg::BIT_WKPU]) &&
			evt.fall_en == $past(reg_wdata[pcc_pkg::BIT_FALL_EN]) &&
			evt.rise_en == $past(reg_wdata[pcc_pkg::BIT_RISE_EN])
	) else $error("enable bits not written");

	a_cfg_hold: assert property (
		!pwr_wr |=>
			$stable({st_q.wkpu, st_q.fall_en, st_q.rise_en, st_q.manual})
	) else $error("enable bits changed without a write");

	a_pullup_off: assert property (
		!st_q.wkpu |=> !dp_weak_pullup_on
	) else $error("pull-up on while disabled");

	a_pullup_on: assert property (
		st_q.wkpu && sync_mode && vbus_session_valid |=> dp_weak_pullup_on
	) else $error("pull-up off although enabled and valid");

	a_no_report: assert property (
		!evt.rise_en && !evt.fall_en && !rxcmd_alt_int_req |=> !rxcmd_alt_int_req
	) else $error("RX CMD request without an enable");

	a_dm_track: assert property (
		1'b1 |=> st_q.dm_above == $past(dm_above_ref)
	) else $error("comparator sample lost");

	a_det_auto: assert property (
		!st_q.manual && !pwr_wr |=>
			st_q.detection_complete == $past(charger_det_result)
	) else $error("completion does not mirror detection");

	a_det_low_manual: assert property (
		st_q.manual |-> !st_q.detection_complete
	) else $error("completion high under manual control");

	a_power_read: assert property (
		reg_re && hit(reg_addr, pcc_pkg::OFS_POWER) |=>
			reg_rdata[pcc_pkg::BIT_FOUND] == $past(st_q.found) &&
			reg_rdata[pcc_pkg::BIT_SRC_EN] == $past(st_q.src_en) &&
			reg_rdata[pcc_pkg::BIT_MANUAL] == $past(st_q.manual)
	) else $error("power read wrong");

	a_status_read: assert property (
		reg_re && hit(reg_addr, pcc_pkg::OFS_IRQ_STATUS) |=>
			reg_rdata[pcc_pkg::IRQ_W-1:0] == $past(evt.status) &&
			reg_rdata[pcc_pkg::DATA_W-1:pcc_pkg::IRQ_W] == '0
	) else $error("status read wrong");

	a_mask_read: assert property (
		reg_re && hit(reg_addr, pcc_pkg::OFS_IRQ_MASK) |=>
			reg_rdata[pcc_pkg::IRQ_W-1:0] == $past(evt.mask) &&
			reg_rdata[pcc_pkg::DATA_W-1:pcc_pkg::IRQ_W] == '0
	) else $error("mask read wrong");

	a_unmapped_read: assert property (
		reg_re && !hit(reg_addr, pcc_pkg::OFS_POWER) && !hit(reg_addr, pcc_pkg::OFS_IRQ_STATUS) &&
			!hit(reg_addr, pcc_pkg::OFS_IRQ_MASK) |=> reg_rdata == pcc_pkg::READ_NONE
	) else $error("unmapped read not zero");

	a_det_event: assert property (
		evt.ev_det |=> evt.status[pcc_pkg::IRQ_DET]
	) else $error("completion event not latched");

	// Only checked without a coincident event, since a set wins over the clear
	a_clear_status: assert property (
		evt.sts_wr && !evt.ev_rise && !evt.ev_fall && !evt.ev_det |=>
			(evt.status & $past(evt.wdata)) == '0
	) else $error("status bits not cleared");

	a_mask_write: assert property (
		evt.msk_wr |=> evt.mask == $past(evt.wdata)
	) else $error("mask write lost");

	c_takeover: cover property (man_rise ##1 st_q.manual ##[1:4] (pwr_wr && reg_wdata[pcc_pkg::BIT_FOUND]));
	c_pullup: cover property (!dp_weak_pullup_on ##1 dp_weak_pullup_on);
	c_rise_report: cover property ($rose(bvalid) && st_q.rise_en ##[1:3] rxcmd_alt_int_req);

endmodule // pcc_power_ctrl
`default_nettype wire

// file: verif/charger_power_control_reg_tb.sv
// Self-checking testbench for the power and charger control register bank
`timescale 1ns/1ps
`default_nettype none
module charger_power_control_reg_tb;
	logic clk, sys_rst, reg_we, reg_re, det, src_live, dm_above, src_on, sink_on, fsm_exit;
	logic sync_mode, vbus_ok, bvalid, wk_on, pol, pin_o, pin_oe, ack, req, irq;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, ack_count;
	logic [1:0] ack_delay;
	int err_total = 0;
	int samples_checked = 0;
	int cycles = 0;
	pcc_power_ctrl dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .charger_det_result(det),
		.hw_src_live(src_live), .dm_above_ref(dm_above), .dp_sense_source_on(src_on),
		.dm_sink_ref_on(sink_on), .det_fsm_exit(fsm_exit), .sync_mode(sync_mode),
		.vbus_session_valid(vbus_ok), .bvalid(bvalid), .dp_weak_pullup_on(wk_on),
		.charger_indicator_polarity(pol), .charger_indicator_pin_o(pin_o),
		.charger_indicator_pin_oe(pin_oe), .rxcmd_alt_int_ack(ack), .rxcmd_alt_int_req(req), .irq(irq));
	pcc_link_model link (.clk(clk), .sys_rst(sys_rst), .alt_int_req(req), .ack_delay(ack_delay),
		.alt_int_ack(ack), .ack_count(ack_count));
	////////////////////////////////////////////////////////////////////////
	initial clk = 1'b0;
	always #4 clk = ~clk;
	// Run needs about five hundred and twenty cycles, the ceiling leaves ample margin
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			err_total++;
			results();
		end
	end
	////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] exp_power(input logic f, s, d, input logic [2:0] cfg, input logic man);
		return {f, s, d, cfg, det & !man, man};
	endfunction
	task results();
		$display("checks=%0d errors=%0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			err_total++;
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_we <= 1'b1;
		@(posedge clk);
		reg_we <= 1'b0;
	endtask
	// Read data stand only in the cycle after the read edge
	task rdc(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_re <= 1'b1;
		@(posedge clk);
		reg_re <= 1'b0;
		#1;
		chk(reg_rdata, e);
	endtask
	task pins(input logic f, input logic s);
		chk({4'h0, pin_oe, pin_o & pin_oe, src_on, sink_on}, {4'h0, f, pol & f, s, s});
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		logic [7:0] w;
		logic [7:0] n;
		logic [7:0] tbl [4];
		logic [1:0] en;
		{sys_rst, reg_we, reg_re, det, src_live, dm_above, sync_mode, vbus_ok, bvalid, pol} = 10'h200;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		ack_delay = 2'h0;
		void'($urandom(21));
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		rdc(pcc_pkg::OFS_POWER, pcc_pkg::POWER_RESET);
		rdc(pcc_pkg::OFS_IRQ_STATUS, 8'h00);
		rdc(8'h55, pcc_pkg::READ_NONE);
		wr(pcc_pkg::OFS_IRQ_MASK, 8'h07);
		rdc(pcc_pkg::OFS_IRQ_MASK, 8'h07);
		// Random automatic-mode traffic, bit 0 kept clear
		for (int i = 0; i < 40; i++) begin
			w = 8'($urandom()) & 8'hFE;
			wr(pcc_pkg::OFS_POWER, w);
			@(posedge clk);
			{det, src_live, dm_above, pol, sync_mode, vbus_ok} <= 6'($urandom());
			repeat (3) @(posedge clk);
			rdc(pcc_pkg::OFS_POWER, exp_power(det, src_live, dm_above, w[4:2], 1'b0));
			pins(det, src_live);
			chk({7'h0, wk_on}, {7'h0, w[4] & sync_mode & vbus_ok});
		end
		// Manual hand-off copies hardware state, then hardware moves away
		@(posedge clk);
		det <= 1'b0;
		wr(pcc_pkg::OFS_IRQ_STATUS, 8'h07);
		@(posedge clk);
		{det, src_live, dm_above, pol} <= 4'hE;
		repeat (2) @(posedge clk);
		wr(pcc_pkg::OFS_POWER, 8'h01);
		@(posedge clk);
		{det, src_live} <= 2'h0;
		repeat (2) @(posedge clk);
		rdc(pcc_pkg::OFS_POWER, 8'hE1);
		chk({7'h0, fsm_exit}, 8'h01);
		rdc(pcc_pkg::OFS_IRQ_STATUS, 8'h04);
		chk({7'h0, irq}, 8'h01);
		pins(1'b1, 1'b1);
		tbl = '{8'h81, 8'h41, 8'hC1, 8'h01};
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			pol <= 1'($urandom());
			wr(pcc_pkg::OFS_POWER, tbl[i]);
			rdc(pcc_pkg::OFS_POWER, tbl[i] | 8'h20);
			pins(tbl[i][7], tbl[i][6]);
		end
		wr(pcc_pkg::OFS_POWER, 8'h00);
		rdc(pcc_pkg::OFS_POWER, 8'h20);
		chk({7'h0, fsm_exit}, 8'h00);
		// BVALID edge reports, last entry merges two edges before the ack
		for (int m = 0; m < 5; m++) begin
			en = (m == 4) ? 2'h3 : 2'(m);
			ack_delay <= (m == 4) ? 2'h3 : 2'($urandom());
			wr(pcc_pkg::OFS_IRQ_STATUS, 8'h07);
			wr(pcc_pkg::OFS_POWER, {4'h0, en, 2'h0});
			n = ack_count;
			@(posedge clk);
			bvalid <= 1'b1;
			repeat ((m == 4) ? 1 : 8) @(posedge clk);
			bvalid <= 1'b0;
			repeat (10) @(posedge clk);
			chk(ack_count - n, (m == 4) ? 8'h01 : 8'(en[0]) + 8'(en[1]));
			rdc(pcc_pkg::OFS_IRQ_STATUS, 8'h03);
			chk({7'h0, irq}, 8'h01);
			wr(pcc_pkg::OFS_IRQ_MASK, 8'h04);
			@(posedge clk);
			#1;
			chk({7'h0, irq}, 8'h00);
			wr(pcc_pkg::OFS_IRQ_MASK, 8'h07);
		end
		wr(pcc_pkg::OFS_IRQ_STATUS, 8'h03);
		rdc(pcc_pkg::OFS_IRQ_STATUS, 8'h00);
		chk({7'h0, irq}, 8'h00);
		results();
	end
endmodule // charger_power_control_reg_tb
`default_nettype wire

// file: verif/pcc_link_model.sv
// Link controller model that takes alt_int RX CMD requests
`timescale 1ns/1ps
`default_nettype none
module pcc_link_model (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// RX CMD handshake
	input wire logic alt_int_req,
	input wire logic [1:0] ack_delay,
	output logic alt_int_ack,
	output logic [7:0] ack_count
);
	logic [1:0] wait_q;
	// Line levels come from RX CMD only, DP and DM are never probed
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			alt_int_ack <= 1'b0;
			ack_count <= 8'h00;
			wait_q <= 2'h0;
		end else begin
			alt_int_ack <= 1'b0;
			// Skip the ack cycle itself, the request is still high there
			if (alt_int_req && !alt_int_ack) begin
				if (wait_q == ack_delay) begin
					alt_int_ack <= 1'b1;
					ack_count <= ack_count + 8'h01;
					wait_q <= 2'h0;
				end else begin
					wait_q <= wait_q + 2'h1;
				end
			end
		end
	end
endmodule // pcc_link_model
`default_nettype wire
